// ==== include/pmcap_params.svh ====
`ifndef PMCAP_PARAMS_SVH
`define PMCAP_PARAMS_SVH
// Byte offsets, same on both interfaces
`define PMCAP_OFF_CAP     8'hDE
`define PMCAP_OFF_CSR     8'hE0
`define PMCAP_OFF_BSE     8'hE2
`define PMCAP_OFF_DATA    8'hE3
// Dword addresses holding the bank
`define PMCAP_DW_CAP      8'hDC
`define PMCAP_DW_CSR      8'hE0
`define PMCAP_DW_MASK     8'hFC
// Capability word layout
`define PMCAP_CAP_RST     16'h0001
`define PMCAP_CAP_LD_MASK 16'h7E27
`define PMCAP_CAP_CLK     3
`define PMCAP_CAP_D1      9
`define PMCAP_CAP_D2      10
`define PMCAP_CAP_SUP_LSB 11
`define PMCAP_CAP_SUP_MSB 15
// Control/status word layout
`define PMCAP_CSR_EN      8
`define PMCAP_CSR_SEL_LSB 9
`define PMCAP_CSR_SEL_MSB 12
`define PMCAP_CSR_STAT    15
`define PMCAP_SCALE_RST   2'h0
`define PMCAP_SEL_RST     4'h0
// Power state codes
`define PMCAP_PS_D0       2'h0
`define PMCAP_PS_D1       2'h1
`define PMCAP_PS_D2       2'h2
`define PMCAP_PS_D3       2'h3
// Fixed byte values
`define PMCAP_BSE_VAL     8'h00
`define PMCAP_DATA_RST    8'h00
`define PMCAP_NUM_DATA    8
`endif

// ==== include/pmcap_pkg.sv ====
package pmcap_pkg;
   typedef logic [1:0]  pmcap_pstate_t;
   typedef logic [7:0]  pmcap_byte_t;
   typedef logic [15:0] pmcap_half_t;
   typedef logic [31:0] pmcap_word_t;
   typedef logic [3:0]  pmcap_be_t;
endpackage

// ==== core/pmcap_regs.sv ====
// Function
// - Bank appears at identical offsets on primary and secondary ports.
// - Capability bits 14:9, 5, 2:0 load from preload port only.
// - Version field resets to 001 and preload may overwrite it.
// - Clock-required bit reads one when any event-support bit is set.
// - Auxiliary power source bit always reads zero.
// - Device-specific init flag resets zero, loadable from preload.
// - D1 and D2 support bits reset zero, loadable from preload.
// - Event support bits 14:11 loadable; bit 15 always zero.
// - Reserved capability and control bits always read zero.
// - Power state field holds D0 to D3, resets to D0.
// - Writes of unimplemented state complete but leave state unchanged.
// - D0 and D3 always accepted; D1, D2 follow support bits.
// - Dynamic data bit always reads zero.
// - Event enable RO zero without support; gates primary event output.
// - Data selector writable only if enabled; 8 to 15 give zero.
// - Data scale resets zero, loadable only from preload port.
// - Event status sets on secondary event when current state supported.
// - Event status clears on write one, ignores zero, resets zero.
// - Bridge extension byte always reads zero.
// - Data byte returns selected preloaded byte or zero; resets zero.
`timescale 1ns/1ns
`include "pmcap_params.svh"
module pmcap_regs
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // Primary configuration port
   input  wire logic                p_req,
   input  wire logic                p_we,
   input  wire pmcap_pkg::pmcap_byte_t p_addr,
   input  wire pmcap_pkg::pmcap_be_t   p_be,
   input  wire pmcap_pkg::pmcap_word_t p_wdata,
   output logic                     p_ack_ff,
   output pmcap_pkg::pmcap_word_t   p_rdata_ff,
   // Secondary configuration port
   input  wire logic                s_req,
   input  wire logic                s_we,
   input  wire pmcap_pkg::pmcap_byte_t s_addr,
   input  wire pmcap_pkg::pmcap_be_t   s_be,
   input  wire pmcap_pkg::pmcap_word_t s_wdata,
   output logic                     s_ack_ff,
   output pmcap_pkg::pmcap_word_t   s_rdata_ff,
   // Preload or local processor load
   input  wire logic                ld_valid,
   input  wire pmcap_pkg::pmcap_half_t ld_cap,
   input  wire logic [1:0]          ld_scale,
   input  wire logic                ld_data_en,
   input  wire logic [63:0]         ld_data_bytes,
   // Event pins, active low
   input  wire logic                s_pme_in_b,
   output logic                     p_pme_out_ff,
   output logic                     p_pme_oe_b_ff
);
   import pmcap_pkg::*;

   pmcap_half_t   cap_ff;
   logic [1:0]    scale_ff;
   logic          data_en_ff;
   pmcap_byte_t   data_mem [`PMCAP_NUM_DATA];
   pmcap_pstate_t state_ff;
   logic          pme_en_ff;
   logic [3:0]    sel_ff;
   logic          pme_stat_ff;
   pmcap_byte_t   data_byte_ff;
   logic          pme_meta_ff;
   logic          pme_sync_ff;
   logic          take_p;
   logic          take_s;
   logic          w_hit;
   pmcap_be_t     w_be;
   pmcap_word_t   w_data;
   logic          sup_any;
   logic          sup_cur;
   logic          pme_set;

   // State acceptance check
   function automatic logic ps_ok(input pmcap_pstate_t ps,
                                  input pmcap_half_t cap);
      case (ps)
         `PMCAP_PS_D0: ps_ok = 1'b1;
         `PMCAP_PS_D1: ps_ok = cap[`PMCAP_CAP_D1];
         `PMCAP_PS_D2: ps_ok = cap[`PMCAP_CAP_D2];
         `PMCAP_PS_D3: ps_ok = 1'b1;
         default:      ps_ok = 1'b0;
      endcase
   endfunction

   // Read word for a byte address, same map on both ports
   function automatic pmcap_word_t rd_word(input pmcap_byte_t a);
      pmcap_half_t cap_rd;
      pmcap_half_t csr_rd;
      cap_rd = cap_ff;
      cap_rd[`PMCAP_CAP_CLK] =
         |cap_ff[`PMCAP_CAP_SUP_MSB:`PMCAP_CAP_SUP_LSB];
      // Masks cover the cycle before the forced clears land
      csr_rd = {pme_stat_ff, scale_ff, sel_ff & {4{data_en_ff}},
                pme_en_ff & sup_any, 6'h00, state_ff};
      if ((a & `PMCAP_DW_MASK) == `PMCAP_DW_CAP)
         rd_word = {cap_rd, 16'h0000};
      else if ((a & `PMCAP_DW_MASK) == `PMCAP_DW_CSR)
         rd_word = {data_byte_ff, `PMCAP_BSE_VAL, csr_rd};
      else
         rd_word = 32'h0000_0000;
   endfunction

   // Arbitration, primary first; secondary waits one turn
   assign take_p = p_req & ~p_ack_ff;
   assign take_s = s_req & ~s_ack_ff & ~take_p;
   assign w_be   = take_p ? p_be : s_be;
   assign w_data = take_p ? p_wdata : s_wdata;
   // Only the control/status dword takes host writes
   assign w_hit  = take_p ?
      (p_we & ((p_addr & `PMCAP_DW_MASK) == `PMCAP_DW_CSR)) :
      (take_s & s_we & ((s_addr & `PMCAP_DW_MASK) == `PMCAP_DW_CSR));

   assign sup_any = |cap_ff[`PMCAP_CAP_SUP_MSB:`PMCAP_CAP_SUP_LSB];
   assign sup_cur = cap_ff[`PMCAP_CAP_SUP_LSB + {3'h0, state_ff}];
   assign pme_set = pme_sync_ff & sup_cur;

   // Answer on primary port
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         p_ack_ff   <= 1'b0;
         p_rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         p_ack_ff   <= take_p;
         p_rdata_ff <= take_p ? rd_word(p_addr) : 32'h0000_0000;
      end
   end

   // Answer on secondary port
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_ack_ff   <= 1'b0;
         s_rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         s_ack_ff   <= take_s;
         s_rdata_ff <= take_s ? rd_word(s_addr) : 32'h0000_0000;
      end
   end

   // Preloaded capability fields, scale and data enable
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cap_ff     <= `PMCAP_CAP_RST;
         scale_ff   <= `PMCAP_SCALE_RST;
         data_en_ff <= 1'b0;
      end
      else if (ld_valid)
      begin
         cap_ff     <= ld_cap & `PMCAP_CAP_LD_MASK;
         scale_ff   <= ld_scale;
         data_en_ff <= ld_data_en;
      end
   end

   // Eight preloaded data bytes
   genvar gi;
   generate
      for (gi = 0; gi < `PMCAP_NUM_DATA; gi++)
      begin : g_data
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
               data_mem[gi] <= `PMCAP_DATA_RST;
            else if (ld_valid)
               data_mem[gi] <= ld_data_bytes[gi*8 +: 8];
         end
      end
   endgenerate

   // Current power state
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         state_ff <= `PMCAP_PS_D0;
      else if (w_hit && w_be[0] && ps_ok(w_data[1:0], cap_ff))
         state_ff <= w_data[1:0];
   end

   // Event enable, held at zero without support
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         pme_en_ff <= 1'b0;
      else if (!sup_any)
         pme_en_ff <= 1'b0;
      else if (w_hit && w_be[1])
         pme_en_ff <= w_data[`PMCAP_CSR_EN];
   end

   // Data selector, only while reporting is enabled
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         sel_ff <= `PMCAP_SEL_RST;
      else if (!data_en_ff)
         sel_ff <= `PMCAP_SEL_RST;
      else if (w_hit && w_be[1])
         sel_ff <= w_data[`PMCAP_CSR_SEL_MSB:`PMCAP_CSR_SEL_LSB];
   end

   // Event status, set wins over a clearing write
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         pme_stat_ff <= 1'b0;
      else if (pme_set)
         pme_stat_ff <= 1'b1;
      else if (w_hit && w_be[1] && w_data[`PMCAP_CSR_STAT])
         pme_stat_ff <= 1'b0;
   end

   // Data byte follows the selector
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         data_byte_ff <= `PMCAP_DATA_RST;
      else if (data_en_ff && !sel_ff[3])
         data_byte_ff <= data_mem[sel_ff[2:0]];
      else
         data_byte_ff <= `PMCAP_DATA_RST;
   end

   // Secondary event pin synchroniser
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pme_meta_ff <= 1'b0;
         pme_sync_ff <= 1'b0;
      end
      else
      begin
         pme_meta_ff <= ~s_pme_in_b;
         pme_sync_ff <= pme_meta_ff;
      end
   end

   // Primary event pin, open drain pulled low when driven
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         p_pme_out_ff  <= 1'b0;
         p_pme_oe_b_ff <= 1'b1;
      end
      else
      begin
         p_pme_out_ff  <= 1'b0;
         p_pme_oe_b_ff <= ~(pme_stat_ff & pme_en_ff);
      end
   end

   // Checks
   a_cap_fixed_bits: assert property (@(posedge clk) disable iff (!rst_b)
      p_ack_ff && (($past(p_addr) & `PMCAP_DW_MASK) == `PMCAP_DW_CAP) |->
      (p_rdata_ff[19] == |p_rdata_ff[31:27]) && !p_rdata_ff[31])
      else $error("capability word malformed");
   a_aps_zero: assert property (@(posedge clk) disable iff (!rst_b)
      p_ack_ff && (($past(p_addr) & `PMCAP_DW_MASK) == `PMCAP_DW_CAP) |->
      (p_rdata_ff[20] == 1'b0) && (p_rdata_ff[24:22] == 3'h0))
      else $error("aps or reserved cap bits set");
   a_bad_state_kept: assert property (@(posedge clk) disable iff (!rst_b)
      w_hit && w_be[0] && !ps_ok(w_data[1:0], cap_ff) |=> $stable(state_ff))
      else $error("unsupported state accepted");
   a_good_state_taken: assert property (@(posedge clk) disable iff (!rst_b)
      w_hit && w_be[0] && ps_ok(w_data[1:0], cap_ff) |=>
      state_ff == $past(w_data[1:0]))
      else $error("supported state not taken");
   a_en_needs_sup: assert property (@(posedge clk) disable iff (!rst_b)
      !sup_any ##1 !sup_any |-> !pme_en_ff)
      else $error("enable set without support");
   a_pin_gated: assert property (@(posedge clk) disable iff (!rst_b)
      !p_pme_oe_b_ff |-> $past(pme_en_ff) && $past(pme_stat_ff))
      else $error("event pin driven while disabled");
   a_stat_sets: assert property (@(posedge clk) disable iff (!rst_b)
      pme_set |=> pme_stat_ff)
      else $error("event status not set");
   a_stat_clears: assert property (@(posedge clk) disable iff (!rst_b)
      w_hit && w_be[1] && w_data[`PMCAP_CSR_STAT] && !pme_set |=>
      !pme_stat_ff)
      else $error("event status not cleared");
   a_stat_zero_write: assert property (@(posedge clk) disable iff (!rst_b)
      pme_stat_ff && !(w_hit && w_be[1] && w_data[`PMCAP_CSR_STAT])
      |=> pme_stat_ff)
      else $error("event status lost");
   a_data_high_sel: assert property (@(posedge clk) disable iff (!rst_b)
      sel_ff[3] |=> data_byte_ff == 8'h00)
      else $error("data byte nonzero for high select");
   a_sel_locked: assert property (@(posedge clk) disable iff (!rst_b)
      !data_en_ff |=> sel_ff == 4'h0)
      else $error("selector set while disabled");
   a_both_ports_same: assert property (@(posedge clk) disable iff (!rst_b)
      p_ack_ff && s_req && !s_ack_ff && (s_addr == $past(p_addr)) &&
      $stable(cap_ff) && $stable(pme_stat_ff) && $stable(state_ff) &&
      $stable(sel_ff) && $stable(pme_en_ff) && $stable(data_byte_ff)
      ##1 s_ack_ff |-> s_rdata_ff == $past(p_rdata_ff))
      else $error("ports disagree");
   a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
      take_p |=> p_ack_ff ##1 !p_ack_ff)
      else $error("primary answer malformed");
   c_state_change: cover property (@(posedge clk) disable iff (!rst_b)
      w_hit && w_be[0] ##1 $changed(state_ff));
   c_event_seen: cover property (@(posedge clk) disable iff (!rst_b)
      pme_set ##[1:8] !p_pme_oe_b_ff);
   c_set_and_clear: cover property (@(posedge clk) disable iff (!rst_b)
      pme_set && w_hit && w_be[1] && w_data[`PMCAP_CSR_STAT]);
   c_port_collision: cover property (@(posedge clk) disable iff (!rst_b)
      p_req && s_req && !p_ack_ff && !s_ack_ff);

endmodule // pmcap_regs

// ==== tb/pmcap_host.sv ====
`timescale 1ns/1ns
module pmcap_host
(
   // Clock
   input  wire logic           clk,
   // Request side
   output logic                req,
   output logic                we,
   output pmcap_pkg::pmcap_byte_t addr,
   output pmcap_pkg::pmcap_be_t   be,
   output pmcap_pkg::pmcap_word_t wdata,
   // Answer side
   input  wire logic           ack,
   input  wire pmcap_pkg::pmcap_word_t rdata
);
   import pmcap_pkg::*;

   // Idle bus at time zero
   initial
   begin
      req = 1'b0;
      we = 1'b0;
      addr = 8'h00;
      be = 4'h0;
      wdata = 32'h0;
   end

   // One config access, held until the answer cycle
   task automatic xfer(input logic w, input pmcap_byte_t a,
                       input pmcap_be_t b, input pmcap_word_t d,
                       output pmcap_word_t q, output logic ok);
      int n;
      ok = 1'b0;
      q = 32'h0;
      @(negedge clk);
      req = 1'b1;
      we = w;
      addr = a;
      be = b;
      wdata = d;
      for (n = 0; n < 20 && !ok; n++)
      begin
         @(posedge clk);
         #1;
         if (ack === 1'b1)
         begin
            ok = 1'b1;
            q = rdata;
         end
      end
      // Released lines show garbage, not the last value
      @(negedge clk);
      req = 1'b0;
      we = ~we;
      addr = ~addr;
      be = ~be;
      wdata = ~wdata;
   endtask
endmodule // pmcap_host

// ==== tb/pmcap_regs_tb.sv ====
`timescale 1ns/1ns
module pmcap_regs_tb;
   import pmcap_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        p_req, p_we, p_ack_ff, s_req, s_we, s_ack_ff;
   pmcap_byte_t p_addr, s_addr;
   pmcap_be_t   p_be, s_be;
   pmcap_word_t p_wdata, s_wdata, p_rdata_ff, s_rdata_ff, q;
   logic        ld_valid = 1'b0;
   pmcap_half_t ld_cap = 16'h0;
   logic [1:0]  ld_scale = 2'h0;
   logic        ld_data_en = 1'b0;
   logic [63:0] ld_data_bytes = 64'h8877665544332211;
   logic        s_pme_in_b = 1'b1;
   logic        p_pme_out_ff, p_pme_oe_b_ff, hit;
   logic [1:0]  ps = 2'h0;
   wire         pme_line;
   int          err_total = 0;
   int          n_tests = 0;

   // Pulled-up primary event line
   assign pme_line = p_pme_oe_b_ff ? 1'b1 : p_pme_out_ff;
   always #5 clk = ~clk;

   pmcap_regs i_pmcap_regs (.clk(clk), .rst_b(rst_b), .p_req(p_req),
      .p_we(p_we), .p_addr(p_addr), .p_be(p_be), .p_wdata(p_wdata),
      .p_ack_ff(p_ack_ff), .p_rdata_ff(p_rdata_ff), .s_req(s_req),
      .s_we(s_we), .s_addr(s_addr), .s_be(s_be), .s_wdata(s_wdata),
      .s_ack_ff(s_ack_ff), .s_rdata_ff(s_rdata_ff), .ld_valid(ld_valid),
      .ld_cap(ld_cap), .ld_scale(ld_scale), .ld_data_en(ld_data_en),
      .ld_data_bytes(ld_data_bytes), .s_pme_in_b(s_pme_in_b),
      .p_pme_out_ff(p_pme_out_ff), .p_pme_oe_b_ff(p_pme_oe_b_ff));
   pmcap_host u_host_p (.clk(clk), .req(p_req), .we(p_we), .addr(p_addr),
      .be(p_be), .wdata(p_wdata), .ack(p_ack_ff), .rdata(p_rdata_ff));
   pmcap_host u_host_s (.clk(clk), .req(s_req), .we(s_we), .addr(s_addr),
      .be(s_be), .wdata(s_wdata), .ack(s_ack_ff), .rdata(s_rdata_ff));

   // Final counts and verdict
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Access on either port; lost answer ends the run
   task automatic acc(input logic sec, input logic w, input pmcap_byte_t a,
                      input pmcap_be_t b, input pmcap_word_t d);
      logic ok;
      if (sec)
         u_host_s.xfer(w, a, b, d, q, ok);
      else
         u_host_p.xfer(w, a, b, d, q, ok);
      if (!ok)
      begin
         err_total++;
         $display("[ERR] ack expected 1 seen 0");
         give_verdict();
      end
   endtask

   // Read and compare
   task automatic rdc(input logic sec, input pmcap_byte_t a,
                      input pmcap_word_t exp, input string nm);
      acc(sec, 1'b0, a, 4'hF, 32'h0);
      chk(nm, q, exp);
   endtask

   // Preload or local processor strobe
   task automatic load(input pmcap_half_t c, input logic [1:0] sc,
                       input logic en);
      @(negedge clk);
      ld_valid = 1'b1;
      ld_cap = c;
      ld_scale = sc;
      ld_data_en = en;
      @(negedge clk);
      ld_valid = 1'b0;
   endtask

   // Secondary event pulse; hit when primary line goes low
   task automatic pulse();
      int n;
      hit = 1'b0;
      @(negedge clk);
      s_pme_in_b = 1'b0;
      for (n = 0; n < 10 && !hit; n++)
      begin
         @(negedge clk);
         hit = (pme_line === 1'b0);
      end
      s_pme_in_b = 1'b1;
      repeat (6) @(negedge clk);
   endtask

   // Expected dword at E0
   function automatic pmcap_word_t ecsr(input logic st, input logic [1:0] sc,
      input logic [3:0] sel, input logic en, input pmcap_byte_t dat);
      return {dat, 8'h00, st, sc, sel, en, 6'h00, ps};
   endfunction

   task automatic t_reset();
      rdc(0, 8'hDC, 32'h0001_0000, "cap_p");
      rdc(1, 8'hDC, 32'h0001_0000, "cap_s");
      rdc(0, 8'hE0, 32'h0, "csr_rst");
      rdc(1, 8'hE4, 32'h0, "unmapped");
   endtask

   task automatic t_protect();
      acc(0, 1, 8'hDC, 4'hF, 32'hFFFF_FFFF);
      rdc(0, 8'hDC, 32'h0001_0000, "cap_ro");
      acc(1, 1, 8'hE0, 4'hF, 32'hFFFF_7FFC);
      rdc(0, 8'hE0, 32'h0, "csr_ro");
   endtask

   task automatic t_pstate();
      load(16'hFFFF, 2'h3, 1'b0);
      rdc(0, 8'hDC, 32'h7E2F_0000, "cap_ld");
      load(16'h7E01, 2'h1, 1'b0);
      rdc(1, 8'hDC, 32'h7E09_0000, "cap_ld2");
      for (int i = 0; i < 4; i++)
      begin
         acc(1, 1, 8'hE0, 4'h1, {30'h0, i[1:0]});
         ps = i[1:0];
         rdc(0, 8'hE0, ecsr(0, 2'h1, 4'h0, 0, 8'h00), "pstate");
      end
      load(16'h7801, 2'h1, 1'b0);
      acc(0, 1, 8'hE0, 4'h1, 32'h0);
      ps = 2'h0;
      for (int i = 1; i < 3; i++)
      begin
         acc(0, 1, 8'hE0, 4'h1, {30'h0, i[1:0]});
         rdc(0, 8'hE0, ecsr(0, 2'h1, 4'h0, 0, 8'h00), "ps_bad");
      end
      acc(0, 1, 8'hE0, 4'h1, 32'h3);
      ps = 2'h3;
   endtask

   task automatic t_data();
      load(16'h7801, 2'h2, 1'b1);
      for (int i = 0; i < 16; i++)
      begin
         acc(0, 1, 8'hE0, 4'h2, {19'h0, i[3:0], 9'h000});
         rdc(1, 8'hE0, ecsr(0, 2'h2, i[3:0], 0, (i < 8) ?
            ld_data_bytes[8*i +: 8] : 8'h00), "sel");
      end
      acc(0, 1, 8'hE0, 4'h2, 32'h0000_0600);
      load(16'h7801, 2'h2, 1'b0);
      rdc(0, 8'hE0, ecsr(0, 2'h2, 4'h0, 0, 8'h00), "data_off");
   endtask

   task automatic t_event();
      acc(0, 1, 8'hE0, 4'h2, 32'h0000_0100);
      pulse();
      chk("line_low", hit, 1'b1);
      rdc(0, 8'hE0, ecsr(1, 2'h2, 4'h0, 1, 8'h00), "stat_set");
      acc(0, 1, 8'hE0, 4'h2, 32'h0000_0100);
      rdc(0, 8'hE0, ecsr(1, 2'h2, 4'h0, 1, 8'h00), "w0_kept");
      acc(0, 1, 8'hE0, 4'h2, 32'h0000_8100);
      rdc(0, 8'hE0, ecsr(0, 2'h2, 4'h0, 1, 8'h00), "w1_clr");
      chk("line_rel", pme_line, 1'b1);
      acc(0, 1, 8'hE0, 4'h2, 32'h0);
      pulse();
      chk("line_gated", hit, 1'b0);
      rdc(1, 8'hE0, ecsr(1, 2'h2, 4'h0, 0, 8'h00), "stat_ungated");
      acc(0, 1, 8'hE0, 4'h2, 32'h0000_8000);
      load(16'h0001, 2'h2, 1'b0);
      rdc(0, 8'hDC, 32'h0001_0000, "clk_req0");
      acc(0, 1, 8'hE0, 4'h2, 32'h0000_0100);
      pulse();
      chk("line_nosup", hit, 1'b0);
      rdc(0, 8'hE0, ecsr(0, 2'h2, 4'h0, 0, 8'h00), "nosup");
   endtask

   // Both ports ask in the same cycle; primary first, same answer
   task automatic t_collide();
      pmcap_word_t qp;
      pmcap_word_t qs;
      logic        okp;
      logic        oks;
      fork
         u_host_p.xfer(1'b0, 8'hE0, 4'hF, 32'h0, qp, okp);
         u_host_s.xfer(1'b0, 8'hE0, 4'hF, 32'h0, qs, oks);
      join
      chk("coll_ack", {okp, oks}, 2'h3);
      chk("coll_p", qp, ecsr(0, 2'h2, 4'h0, 0, 8'h00));
      chk("coll_s", qs, ecsr(0, 2'h2, 4'h0, 0, 8'h00));
   endtask

   // Main sequence
   initial
   begin
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      t_reset();
      t_protect();
      t_pstate();
      t_data();
      t_event();
      t_collide();
      give_verdict();
   end
endmodule // pmcap_regs_tb
